// ---- verilog/qdm_flash_params.sv ----
// What this block does (R1-R21); R22-R24 are what the host does
// (R1) dummy word one 11:7 is 200MHz count
// (R2) dummy word one 6:2 is 200MHz pattern
// (R3) word two 31:27 166MHz count, 26:22 pattern
// (R4) word two 21:17 133MHz count, 16:12 pattern
// (R5) word two 11:7 100MHz count, 6:2 pattern
// (R6) reserved dummy word bits read zero
// (R7) sequences give quad DDR, type0, 20 dummies
// (R8) after switch, parameter reads stop answering
// (R9) device booting in target mode needs no switch
// (R10) each sequence framed by chip select low
// (R11) sequence is length byte plus seven bytes
// (R12) zero length sequence is skipped
// (R13) byte slots past length are ignored
// (R14) up to four sequences, taken in order
// (R15) wrong clock count discards the sequence
// (R16) header one 31:24 table length in words
// (R17) header one major 1, minor 0
// (R18) table id 09h low, FFh high
// (R19) header two 23:0 word aligned table start
// (R20) sequence word byte order, length on top
// (R21) trailing absent entries shorten the table
// (R22) host finds boot mode first if not single
// (R23) host then switches itself to quad DDR
// (R24) host fetches first, gaps between sequences
`timescale 1ns/1ps
module qdm_flash_params #(
   parameter logic [23:0] TABLE_PTR = qdm_pkg::TABLE_PTR_DEF
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  sck,
   input  wire logic                  cs_n,
   input  wire logic                  mosi,
   input  wire logic                  boot_quad_ddr,
   input  wire logic [3:0][4:0]       dc_count,
   input  wire logic [3:0][4:0]       dc_pattern,
   input  wire logic [3:0][2:0]       seq_len,
   input  wire logic [3:0][6:0][7:0]  seq_byte,
   output logic                       miso_o,
   output logic                       miso_oe,
   output logic                       params_ready,
   output logic                       quad_ddr_mode,
   output logic                       drive_type0,
   output logic [4:0]                 fast_dummy
);
   qdm_mem_if mif ();

   qdm_param_mem #(.WORDS(qdm_pkg::MEM_WORDS)) u_mem (
      .wr_clk (ref_clk),
      .rd_clk (sck),
      .bus    (mif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // first required sequence at or after a position
   function automatic logic [2:0] next_seq(input logic [2:0] from,
                                           input logic [3:0][2:0] lens);
      logic [2:0] r;
      r = qdm_pkg::SEQ_NONE;
      for (int i = qdm_pkg::NUM_SEQ - 1; i >= 0; i--) begin
         if (3'(i) >= from && lens[i] != 3'h0) begin
            r = 3'(i); // R12
         end
      end
      return r;
   endfunction

   // table length in words, trailing empty sequences dropped
   function automatic logic [7:0] table_words(input logic [3:0][2:0] lens);
      logic [7:0] w;
      w = 8'h02;
      for (int i = 0; i < qdm_pkg::NUM_SEQ; i++) begin
         if (lens[i] != 3'h0) begin
            w = 8'((i + 1) * 2); // R21
         end
      end
      return w;
   endfunction

   // builds one parameter word from the strap ports
   function automatic logic [31:0] build_word(input logic [3:0] idx,
                                              input logic [3:0][4:0] cnt,
                                              input logic [3:0][4:0] pat,
                                              input logic [3:0][2:0] lens,
                                              input logic [3:0][6:0][7:0] sb,
                                              input logic [23:0] ptr);
      logic [31:0] w;
      logic [3:0]  rel;
      logic [1:0]  s;
      w   = 32'h0000_0000; // R6
      rel = idx - qdm_pkg::IDX_SEQ0;
      s   = rel[2:1];
      case (idx)
         qdm_pkg::IDX_HDR1: begin
            w[qdm_pkg::HDR_LEN_LSB +: 8] = table_words(lens); // R16
            w[qdm_pkg::HDR_MAJ_LSB +: 8] = qdm_pkg::TABLE_MAJOR; // R17
            w[qdm_pkg::HDR_MIN_LSB +: 8] = qdm_pkg::TABLE_MINOR; // R17
            w[7:0]                       = qdm_pkg::TABLE_ID_LSB; // R18
         end
         qdm_pkg::IDX_HDR2: begin
            w[qdm_pkg::HDR_IDM_LSB +: 8] = qdm_pkg::TABLE_ID_MSB; // R18
            w[23:0]                      = {ptr[23:2], 2'b00}; // R19
         end
         qdm_pkg::IDX_DUMMY1: begin
            w[qdm_pkg::DC_LO_CNT_LSB +: 5] = cnt[3]; // R1
            w[qdm_pkg::DC_LO_PAT_LSB +: 5] = pat[3]; // R2
         end
         qdm_pkg::IDX_DUMMY2: begin
            w[qdm_pkg::DC_HI_CNT_LSB +: 5]  = cnt[2]; // R3
            w[qdm_pkg::DC_HI_PAT_LSB +: 5]  = pat[2]; // R3
            w[qdm_pkg::DC_MID_CNT_LSB +: 5] = cnt[1]; // R4
            w[qdm_pkg::DC_MID_PAT_LSB +: 5] = pat[1]; // R4
            w[qdm_pkg::DC_LO_CNT_LSB +: 5]  = cnt[0]; // R5
            w[qdm_pkg::DC_LO_PAT_LSB +: 5]  = pat[0]; // R5
         end
         default: begin
            // sequence words, absent past the table length
            if (idx >= qdm_pkg::IDX_SEQ0 && idx < qdm_pkg::IDX_BLANK
                && {4'h0, rel} < table_words(lens)) begin
               if (!rel[0]) begin
                  w = {5'h00, lens[s], sb[s][0], sb[s][1], sb[s][2]}; // R11 R20
               end else begin
                  w = {sb[s][3], sb[s][4], sb[s][5], sb[s][6]}; // R20
               end
            end
         end
      endcase
      return w;
   endfunction

   // maps a byte address to a memory word index
   function automatic logic [3:0] word_index(input logic [23:0] a,
                                             input logic [23:0] ptr);
      logic [3:0]  r;
      logic [23:0] off;
      r   = qdm_pkg::IDX_BLANK;
      off = a - {ptr[23:2], 2'b00};
      if (a[23:3] == qdm_pkg::HDR_ADDR[23:3]) begin
         r = {3'h0, a[2]};
      end else if (a[23:3] == qdm_pkg::DUMMY_ADDR[23:3]) begin
         r = {3'h1, a[2]};
      end else if (off[23:5] == 19'h0) begin
         r = {1'b0, off[4:2]} + qdm_pkg::IDX_SEQ0;  // four bits, no wrap past index 7
      end
      return r;
   endfunction

   // compares a received frame against one stored sequence
   function automatic logic seq_match(input logic [55:0] rx, input logic [6:0] bits,
                                      input logic [2:0] len, input logic [6:0][7:0] b);
      logic ok;
      ok = (bits == {1'b0, len, 3'b000}); // R15
      for (int i = 0; i < qdm_pkg::SEQ_BYTES; i++) begin
         if (3'(i) < len && rx[8 * (int'(len) - 1 - i) +: 8] != b[i]) begin
            ok = 1'b0; // R13
         end
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link domain: frame capture on sck

   logic        fresh_q;                // next edge is a frame's first
   logic [6:0]  bit_cnt_q, bit_cnt_d;   // bits seen in frame, saturating
   logic [55:0] rx_q, rx_d;             // last seven bytes shifted in
   logic [7:0]  cmd_q, cmd_d;           // opcode byte
   logic [23:0] addr_q, addr_d;         // current read byte address
   logic        in_data_q, in_data_d;   // read reply phase
   logic [2:0]  db_q, db_d;             // bit within reply byte
   logic [1:0]  quad_l_q, quad_l_d;     // mode flag synchroniser
   logic [1:0]  rdy_l_q, rdy_l_d;       // load done synchroniser
   logic        quad_q, quad_d;         // switched to quad DDR, system clock
   logic        ready_q, ready_d;       // table loaded, system clock

   // frame start marker, set while chip select is high
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         fresh_q <= 1'b1; // R10
      end else begin
         fresh_q <= 1'b0;
      end
   end

   // next state of frame capture
   always_comb begin
      bit_cnt_d = fresh_q ? 7'h01
                : (bit_cnt_q == qdm_pkg::BIT_CNT_MAX ? bit_cnt_q : bit_cnt_q + 7'h01);
      rx_d      = {rx_q[54:0], mosi};
      cmd_d     = cmd_q;
      addr_d    = addr_q;
      in_data_d = fresh_q ? 1'b0 : in_data_q;
      db_d      = db_q + 3'h1;
      quad_l_d  = {quad_l_q[0], quad_q};
      rdy_l_d   = {rdy_l_q[0], ready_q};
      if (bit_cnt_d == 7'h08) begin
         cmd_d = rx_d[7:0];
      end
      if (bit_cnt_d == qdm_pkg::ADDR_END_BIT) begin
         addr_d = rx_d[23:0];
      end
      // reply only in single mode once the table is built
      if (bit_cnt_d == qdm_pkg::DATA_START_BIT && cmd_q == qdm_pkg::CMD_READ_PARAM
          && rdy_l_q[1] && !quad_l_q[1]) begin
         in_data_d = 1'b1; // R8
         db_d      = 3'h0;
      end
      // step address one bit early so the word read is ready
      if (in_data_q && db_d == 3'h7) begin
         addr_d = addr_q + 24'h000001;
      end
   end

   // frame capture registers
   always_ff @(posedge sck) begin
      bit_cnt_q <= bit_cnt_d;
      rx_q      <= rx_d;
      cmd_q     <= cmd_d;
      addr_q    <= addr_d;
      in_data_q <= in_data_d;
      db_q      <= db_d;
      quad_l_q  <= quad_l_d;
      rdy_l_q   <= rdy_l_d;
   end

   assign mif.rd_idx = word_index(addr_q, TABLE_PTR);

   ////////////////////////////////////////////////////////////////////////////
   // link domain: reply shifter on falling sck

   logic [7:0] sh_q, sh_d;   // reply byte shifter
   logic       oe_q, oe_d;   // reply drive enable

   // loads a byte at its first bit, else shifts
   always_comb begin
      sh_d = {sh_q[6:0], 1'b0};
      oe_d = in_data_q;
      if (in_data_q && db_q == 3'h0) begin
         sh_d = 8'(mif.rd_data >> {addr_q[1:0], 3'b000});
      end
   end

   // released as soon as chip select rises
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         sh_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         oe_q <= oe_d;
      end
   end

   assign miso_o  = sh_q[7];
   assign miso_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // system domain: table load and mode switch

   qdm_pkg::qdm_state_t st_q, st_d;   // load then run
   logic [3:0]  ld_idx_q, ld_idx_d;   // word being loaded
   logic [2:0]  cs_s_q, cs_s_d;       // chip select sync plus history
   logic [1:0]  boot_s_q, boot_s_d;   // boot strap synchroniser
   logic [2:0]  exp_q, exp_d;         // next expected sequence
   logic        frame_end;

   // frame ends on a synchronised chip select rise; sck has stopped,
   // so the captured bit count and bytes are steady when read here
   assign frame_end = cs_s_q[1] && !cs_s_q[2];

   // next state of load and switch
   always_comb begin
      st_d        = st_q;
      ld_idx_d    = ld_idx_q;
      cs_s_d      = {cs_s_q[1:0], cs_n};
      boot_s_d    = {boot_s_q[0], boot_quad_ddr};
      exp_d       = exp_q;
      quad_d      = quad_q;
      ready_d     = ready_q;
      mif.wr_en   = 1'b0;
      mif.wr_idx  = ld_idx_q;
      mif.wr_data = build_word(ld_idx_q, dc_count, dc_pattern, seq_len, seq_byte,
                               TABLE_PTR);
      case (st_q)
         qdm_pkg::ST_LOAD: begin
            mif.wr_en = 1'b1;
            ld_idx_d  = ld_idx_q + 4'h1;
            if (ld_idx_q == qdm_pkg::IDX_BLANK) begin
               st_d    = qdm_pkg::ST_RUN;
               ready_d = 1'b1;
               exp_d   = next_seq(3'h0, seq_len); // R14
               if (next_seq(3'h0, seq_len) == qdm_pkg::SEQ_NONE) begin
                  quad_d = 1'b1;
               end
            end
         end
         qdm_pkg::ST_RUN: begin
            // a matching frame advances; anything else is discarded
            if (frame_end && !quad_q && exp_q != qdm_pkg::SEQ_NONE
                && seq_match(rx_q, bit_cnt_q, seq_len[exp_q[1:0]],
                             seq_byte[exp_q[1:0]])) begin // R15
               exp_d = next_seq(exp_q + 3'h1, seq_len); // R14
               if (next_seq(exp_q + 3'h1, seq_len) == qdm_pkg::SEQ_NONE) begin
                  quad_d = 1'b1; // R7
               end
            end
         end
         default: begin
            st_d = qdm_pkg::ST_LOAD;
         end
      endcase
      if (rst) begin
         st_d     = qdm_pkg::ST_LOAD;
         ld_idx_d = 4'h0;
         exp_d    = qdm_pkg::SEQ_NONE;
         quad_d   = boot_s_q[1]; // R9
         ready_d  = 1'b0;
      end
   end

   // system domain registers
   always_ff @(posedge ref_clk) begin
      st_q     <= st_d;
      ld_idx_q <= ld_idx_d;
      cs_s_q   <= cs_s_d;
      boot_s_q <= boot_s_d;
      exp_q    <= exp_d;
      quad_q   <= quad_d;
      ready_q  <= ready_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // status outputs

   logic [4:0] dummy_q, dummy_d;   // fast read dummy cycles in force

   // operating point follows the mode flag
   always_comb begin
      dummy_d = quad_q ? qdm_pkg::TARGET_DUMMY : 5'h00; // R7
   end

   always_ff @(posedge ref_clk) begin
      dummy_q <= dummy_d;
   end

   assign params_ready  = ready_q;
   assign quad_ddr_mode = quad_q;
   assign drive_type0   = quad_q;
   assign fast_dummy    = dummy_q;
endmodule

// ---- shared/qdm_pkg.sv ----
package qdm_pkg;
   // link command and framing
   localparam logic [7:0]  CMD_READ_PARAM = 8'h5A;  // parameter read opcode
   localparam logic [6:0]  ADDR_END_BIT   = 7'h20;  // 8 cmd + 24 address bits
   localparam logic [6:0]  DATA_START_BIT = 7'h28;  // after 8 dummy clocks
   localparam logic [6:0]  BIT_CNT_MAX    = 7'h7F;  // saturation of frame bit count
   // parameter space map (byte addresses)
   localparam logic [23:0] HDR_ADDR       = 24'h000008; // two header words
   localparam logic [23:0] DUMMY_ADDR     = 24'h000060; // two dummy-cycle words
   localparam logic [23:0] TABLE_PTR_DEF  = 24'h000080; // table start, word aligned
   // memory word indices
   localparam logic [3:0]  IDX_HDR1       = 4'h0;
   localparam logic [3:0]  IDX_HDR2       = 4'h1;
   localparam logic [3:0]  IDX_DUMMY1     = 4'h2;
   localparam logic [3:0]  IDX_DUMMY2     = 4'h3;
   localparam logic [3:0]  IDX_SEQ0       = 4'h4;
   localparam logic [3:0]  IDX_BLANK      = 4'hF;   // always zero
   localparam int          MEM_WORDS      = 16;
   // header fields
   localparam int          HDR_LEN_LSB    = 24;
   localparam int          HDR_MAJ_LSB    = 16;
   localparam int          HDR_MIN_LSB    = 8;
   localparam int          HDR_IDM_LSB    = 24;
   localparam logic [7:0]  TABLE_MAJOR    = 8'h01;
   localparam logic [7:0]  TABLE_MINOR    = 8'h00;
   localparam logic [7:0]  TABLE_ID_LSB   = 8'h09;
   localparam logic [7:0]  TABLE_ID_MSB   = 8'hFF;
   // dummy-cycle word fields
   localparam int          DC_HI_CNT_LSB  = 27;
   localparam int          DC_HI_PAT_LSB  = 22;
   localparam int          DC_MID_CNT_LSB = 17;
   localparam int          DC_MID_PAT_LSB = 12;
   localparam int          DC_LO_CNT_LSB  = 7;
   localparam int          DC_LO_PAT_LSB  = 2;
   // sequence layout
   localparam int          NUM_SEQ        = 4;
   localparam int          SEQ_BYTES      = 7;
   localparam logic [2:0]  SEQ_NONE       = 3'h4;   // no sequence left
   // target operating point after the switch
   localparam logic [4:0]  TARGET_DUMMY   = 5'h14;  // 20 fast read dummy cycles
   // control sequencing
   typedef enum logic [0:0] {ST_LOAD, ST_RUN} qdm_state_t;
endpackage

// ---- shared/qdm_mem_if.sv ----
`timescale 1ns/1ps
interface qdm_mem_if;
   logic        wr_en;    // write strobe, writer clock
   logic [3:0]  wr_idx;   // write word index
   logic [31:0] wr_data;  // write word
   logic [3:0]  rd_idx;   // read word index, reader clock
   logic [31:0] rd_data;  // registered read word
   modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
   modport user (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
endinterface

// ---- verilog/qdm_param_mem.sv ----
`timescale 1ns/1ps
module qdm_param_mem #(
   parameter int WORDS = qdm_pkg::MEM_WORDS
) (
   input  wire logic wr_clk,
   input  wire logic rd_clk,
   qdm_mem_if.mem    bus
);
   logic [31:0] mem_q [WORDS];  // parameter words
   logic [31:0] rd_q;           // read register
   logic [31:0] rd_d;

   // write port, loaded once after reset, static afterwards
   always_ff @(posedge wr_clk) begin
      if (bus.wr_en) begin
         mem_q[bus.wr_idx] <= bus.wr_data;
      end
   end

   // read select
   always_comb begin
      rd_d = mem_q[bus.rd_idx];
   end

   // read data out of a register on the link clock
   always_ff @(posedge rd_clk) begin
      rd_q <= rd_d;
   end

   assign bus.rd_data = rd_q;
endmodule

// ---- dv/qdm_flash_params_checker.sv ----
`timescale 1ns/1ps
module qdm_flash_params_checker (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       miso_oe,
   input wire logic       params_ready,
   input wire logic       quad_ddr_mode,
   input wire logic       drive_type0,
   input wire logic [4:0] fast_dummy
);
   ////////////////////////////////////////
   logic [4:0] ld_q;  // cycles since reset release
   logic [4:0] ld_d;
   logic [6:0] bit_q; // link rising edges in frame
   logic [6:0] bit_d;
   // saturating counts, no wrap back to zero
   always_comb begin
      ld_d  = (ld_q == 5'h1F) ? ld_q : ld_q + 5'h01;
      bit_d = (bit_q == 7'h7F) ? bit_q : bit_q + 7'h01;
   end
   // load timer, cleared by reset
   always_ff @(posedge ref_clk) begin
      ld_q <= rst ? 5'h00 : ld_d;
   end
   // frame bit count, cleared while chip select high
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_q <= 7'h00;
      end else begin
         bit_q <= bit_d;
      end
   end
   ////////////////////////////////////////
   sequence s_quad_two;
      quad_ddr_mode ##1 quad_ddr_mode;
   endsequence
   sequence s_plain_two;
      !quad_ddr_mode ##1 !quad_ddr_mode;
   endsequence
   property p_ready_early;
      @(posedge ref_clk) disable iff (rst) params_ready |-> ld_q >= 5'h0C;
   endproperty
   property p_ready_late;
      @(posedge ref_clk) disable iff (rst) ld_q >= 5'h14 |-> params_ready;
   endproperty
   property p_quad_hold;
      @(posedge ref_clk) disable iff (rst) quad_ddr_mode |=> quad_ddr_mode;
   endproperty
   property p_dt0;
      @(posedge ref_clk) disable iff (rst) drive_type0 == quad_ddr_mode;
   endproperty
   property p_fast_on;
      @(posedge ref_clk) disable iff (rst) s_quad_two |-> fast_dummy == qdm_pkg::TARGET_DUMMY;
   endproperty
   property p_fast_off;
      @(posedge ref_clk) disable iff (rst) s_plain_two |-> fast_dummy == 5'h00;
   endproperty
   property p_oe_cs;
      @(posedge ref_clk) disable iff (rst) miso_oe |-> !cs_n;
   endproperty
   property p_oe_refuse;
      @(posedge ref_clk) disable iff (rst) miso_oe |-> params_ready && !quad_ddr_mode;
   endproperty
   property p_quad_rise;
      @(posedge ref_clk) disable iff (rst)
         $rose(quad_ddr_mode) |-> $past(cs_n, 1) && $past(cs_n, 3);
   endproperty
   property p_oe_start;
      @(negedge sck) disable iff (cs_n) $rose(miso_oe) |-> bit_q == 7'h29;
   endproperty
   a_ready_early: assert property (p_ready_early)
      else $error("table ready too early");
   a_ready_late: assert property (p_ready_late)
      else $error("table not ready in time");
   a_quad_hold: assert property (p_quad_hold)
      else $error("quad mode dropped");
   a_dt0: assert property (p_dt0)
      else $error("driver type differs from mode");
   a_fast_on: assert property (p_fast_on)
      else $error("fast dummy not 20 in quad mode");
   a_fast_off: assert property (p_fast_off)
      else $error("fast dummy set outside quad mode");
   a_oe_cs: assert property (p_oe_cs)
      else $error("reply driven while deselected");
   a_oe_refuse: assert property (p_oe_refuse)
      else $error("reply while not allowed");
   a_quad_rise: assert property (p_quad_rise)
      else $error("mode switched inside a frame");
   a_oe_start: assert property (p_oe_start)
      else $error("reply started at wrong bit");
endmodule

bind qdm_flash_params qdm_flash_params_checker u_chk (
   .ref_clk      (ref_clk),
   .rst          (rst),
   .sck          (sck),
   .cs_n         (cs_n),
   .miso_oe      (miso_oe),
   .params_ready (params_ready),
   .quad_ddr_mode(quad_ddr_mode),
   .drive_type0  (drive_type0),
   .fast_dummy   (fast_dummy)
);

// ---- dv/qdm_host_model.sv ----
`timescale 1ns/1ps
module qdm_host_model (
   output logic        sck,
   output logic        cs_n,
   output logic        mosi,
   input  wire logic   miso_o,
   input  wire logic   miso_oe,
   output logic        done,
   output logic [31:0] word
);
   ////////////////////////////////////////
   localparam logic [31:0] NO_REPLY = 32'hEEEE_EEEE; // marker, frame got no reply
   localparam int          HALF     = 80;            // half link period, ns
   logic tog = 1'b0;                                 // changes each link cycle
   wire  line_in = miso_oe ? miso_o : tog;           // undriven line never holds
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      done = 1'b0;
      word = 32'h0000_0000;
   end
   always @(posedge sck) begin
      tog <= ~tog;
   end
   // one link clock, stands low between pulses
   task automatic pulse();
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
   endtask
   // idle clocks with chip select high, lets ready reach the link side
   task automatic warm();
      repeat (2) pulse();
   endtask
   // frame: nb bits of v from the top, then nw reply words
   task automatic xfer(input logic [63:0] v, input int nb, input int nw);
      logic [31:0] w;
      logic        seen;
      int          i;
      int          k;
      // odd offset keeps link edges off the system clock edges
      #7 cs_n = 1'b0;
      for (i = 0; i < nb; i++) begin
         mosi = v[63-i];
         pulse();
      end
      for (k = 0; k < nw; k++) begin
         seen = 1'b0;
         for (i = 0; i < 32; i++) begin
            #HALF sck = 1'b1;
            w[8*(i/8)+7-(i%8)] = line_in; // byte lsb first, bit msb first
            seen = seen | miso_oe;
            #HALF sck = 1'b0;
         end
         word = seen ? w : NO_REPLY;
         done = 1'b1;
         #1 done = 1'b0;
      end
      #HALF cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule

// ---- dv/tb_quad_ddr_mode_switch_sequencer.sv ----
`timescale 1ns/1ps
module tb_quad_ddr_mode_switch_sequencer;
   ////////////////////////////////////////
   logic                 ref_clk, rst, boot_quad_ddr, mode_ev;
   logic [3:0][4:0]      dc_count, dc_pattern;
   logic [3:0][2:0]      seq_len;
   logic [3:0][6:0][7:0] seq_byte;
   wire                  sck, cs_n, mosi, miso_o, miso_oe, host_done;
   wire                  params_ready, quad_ddr_mode, drive_type0;
   wire  [4:0]           fast_dummy;
   wire  [31:0]          host_word;
   logic [31:0]          exp_q[$]; // expected results, oldest first
   int                   n_fail, num_checks, cyc;
   qdm_flash_params #(.TABLE_PTR(qdm_pkg::TABLE_PTR_DEF)) dut (
      .ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
      .boot_quad_ddr(boot_quad_ddr), .dc_count(dc_count), .dc_pattern(dc_pattern),
      .seq_len(seq_len), .seq_byte(seq_byte), .miso_o(miso_o), .miso_oe(miso_oe),
      .params_ready(params_ready), .quad_ddr_mode(quad_ddr_mode),
      .drive_type0(drive_type0), .fast_dummy(fast_dummy));
   qdm_host_model host (
      .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
      .done(host_done), .word(host_word));
   ////////////////////////////////////////
   // clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // compare each result with the oldest note
   always @(posedge host_done or posedge mode_ev) begin : mon
      logic [31:0] g;
      logic [31:0] e;
      g = mode_ev ? {25'h0, quad_ddr_mode, drive_type0, fast_dummy} : host_word;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~g;
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t exp %h got %h", $time, e, g);
      end
   end
   task automatic report_and_stop();
      if (exp_q.size() != 0) n_fail++;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // expected sequence word, absent past the table length
   function automatic logic [31:0] seq_w(input int s, input int h);
      if (2 * s + h >= 6) return 32'h0;
      if (h != 0) return {seq_byte[s][3], seq_byte[s][4], seq_byte[s][5], seq_byte[s][6]};
      return {5'h00, seq_len[s], seq_byte[s][0], seq_byte[s][1], seq_byte[s][2]};
   endfunction
   task automatic rd(input logic [7:0] cmd, input logic [23:0] a, input int n);
      host.xfer({cmd, a, 8'h00, 24'h0}, 40, n);
   endtask
   // sequence s with extra clocks added on purpose
   task automatic seq(input int s, input int extra);
      logic [63:0] v;
      int          i;
      v = 64'h0;
      for (i = 0; i < 7; i++) v[63-8*i -: 8] = seq_byte[s][i];
      host.xfer(v, 8 * seq_len[s] + extra, 0);
   endtask
   task automatic mode(input logic q);
      @(negedge ref_clk);
      exp_q.push_back({25'h0, q, q, q ? qdm_pkg::TARGET_DUMMY : 5'h00});
      mode_ev = 1'b1;
      #1 mode_ev = 1'b0;
   endtask
   task automatic reset_wait();
      int i;
      rst = 1'b1;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      for (i = 0; i < 200 && params_ready !== 1'b1; i++) @(negedge ref_clk);
      host.warm();
   endtask
   ////////////////////////////////////////
   initial begin
      int k;
      int i;
      {rst, boot_quad_ddr, mode_ev} = 3'b100;
      {n_fail, num_checks, cyc} = '0;
      seq_len  = {3'h0, 3'h7, 3'h0, 3'h2}; // zero in the middle and at the end
      seq_byte = '0;
      {dc_count, dc_pattern} = '0;
      void'($urandom(32'hc08d));
      @(negedge ref_clk);
      for (k = 0; k < 4; k++) begin
         dc_count[k]   = 5'($urandom_range(31, 1));
         dc_pattern[k] = 5'($urandom);
         for (i = 0; i < seq_len[k]; i++) seq_byte[k][i] = 8'($urandom);
      end
      reset_wait();
      exp_q.push_back({8'h06, qdm_pkg::TABLE_MAJOR, qdm_pkg::TABLE_MINOR,
                       qdm_pkg::TABLE_ID_LSB});
      exp_q.push_back({qdm_pkg::TABLE_ID_MSB, qdm_pkg::TABLE_PTR_DEF});
      rd(qdm_pkg::CMD_READ_PARAM, qdm_pkg::HDR_ADDR, 2);
      exp_q.push_back({20'h0, dc_count[3], dc_pattern[3], 2'b00});
      exp_q.push_back({dc_count[2], dc_pattern[2], dc_count[1], dc_pattern[1],
                       dc_count[0], dc_pattern[0], 2'b00});
      rd(qdm_pkg::CMD_READ_PARAM, qdm_pkg::DUMMY_ADDR, 2);
      for (k = 0; k < 8; k++) exp_q.push_back(seq_w(k / 2, k % 2));
      rd(qdm_pkg::CMD_READ_PARAM, qdm_pkg::TABLE_PTR_DEF, 8);
      exp_q.push_back(host.NO_REPLY); // unknown opcode gets no reply
      rd(8'h03, qdm_pkg::HDR_ADDR, 1);
      seq(2, 0);
      mode(1'b0);
      seq(0, 1);
      mode(1'b0);
      seq(0, 0);
      mode(1'b0);
      seq(2, 0);
      mode(1'b1);
      exp_q.push_back(host.NO_REPLY);
      rd(qdm_pkg::CMD_READ_PARAM, qdm_pkg::HDR_ADDR, 1);
      @(negedge ref_clk);
      boot_quad_ddr = 1'b1;
      reset_wait();
      mode(1'b1);
      report_and_stop();
   end
endmodule
